// *** common/ebw_pkg.sv ***
// package: constants, register layout and carrier types of the external bus block
package ebw_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int ADDR_W = 24;                 // external address width
    localparam int DATA_W = 32;                 // external data width
    localparam int REG_AW = 8;                  // register port address width
    localparam int ROM_AW = 12;                 // boot rom word address width

    // ****************************************
    // register map and field layout
    // ****************************************
    localparam logic [7:0] CTRL_OFS = 8'h00;    // bus control register
    localparam logic [7:0] STAT_OFS = 8'h04;    // bus status register
    localparam int SEL_LSB  = 3;                // ready source select, bits 4:3
    localparam int WCNT_LSB = 5;                // wait count field, bits 7:5
    localparam int BNK_LSB  = 8;                // bank compare field, bits 12:8

    // ready source encodings
    localparam logic [1:0] RDY_PIN = 2'h0;      // external pin only
    localparam logic [1:0] RDY_CNT = 2'h1;      // internal counter only
    localparam logic [1:0] RDY_AND = 2'h2;      // pin and counter, and-combined
    localparam logic [1:0] RDY_OR  = 2'h3;      // pin and counter, or-combined

    // reset values
    localparam logic [1:0] SEL_RST  = RDY_OR;
    localparam logic [2:0] WCNT_RST = 3'h7;
    localparam logic [4:0] BNK_RST  = 5'h00;

    // boot rom window and page bits
    localparam logic [23:0] ROM_HI = 24'h000FFF; // last address of the boot rom
    localparam int PAGE_LO = 22;                 // low page address bit

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        EBW_IDLE = 2'h0,                        // bus quiet, latch empty
        EBW_NULL = 2'h1,                        // null cycle before a new-bank read
        EBW_ACC  = 2'h3,                        // strobe low, waiting for ready
        EBW_ROM  = 2'h2                         // internal rom read
    } ebw_state_t;

    typedef struct packed {
        logic [1:0] rdy_sel;                    // ready source select
        logic [2:0] wait_cnt;                   // wait count field
        logic [4:0] bank_cmp;                   // bank compare field
    } ebw_ctrl_t;

    typedef struct packed {
        logic              we;                  // 1 = write
        logic [ADDR_W-1:0] addr;                // word address
        logic [DATA_W-1:0] data;                // write data
    } ebw_req_t;

    typedef struct packed {
        ebw_state_t        st;                  // bus sequencer state
        ebw_ctrl_t         ctrl;                // bus control register
        ebw_req_t          req;                 // posted request latch
        logic [ADDR_W-1:0] last_addr;           // address of the previous access
        logic              last_valid;          // previous access exists
        logic [2:0]        wcnt;                // wait-state counter
        logic [DATA_W-1:0] reg_rdata;           // register read data
        logic [DATA_W-1:0] rd_data;             // cpu read data
        logic              rd_valid;            // cpu read data valid
        logic              cpu_ready;           // latch can take a request
        logic [ADDR_W-1:0] ext_addr;            // address pins
        logic              ext_rw;              // 1 = read
        logic              strobe_n;            // bus strobe, active low
        logic [3:0]        page_n;              // page selects, active low
        logic [DATA_W-1:0] dout;                // data pin output value
        logic              drive;               // data pins driven by us
        logic [ROM_AW-1:0] rom_addr;            // boot rom address
    } ebw_state_s_t;

    // top bits of the address that take part in the bank compare
    function automatic logic [ADDR_W-1:0] bank_mask(input logic [4:0] n);
        logic [ADDR_W-1:0] m;
        m = '0;
        for (int i = 0; i < ADDR_W; i++) begin
            if (i >= ADDR_W - int'(n)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

endpackage

// *** core/ebw_bus_ctrl.sv ***
// module: external bus sequencer with page selects, wait states and latched requests
`timescale 1ns/100ps
module ebw_bus_ctrl
    import ebw_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // register port
    input  wire logic [REG_AW-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [DATA_W-1:0]      reg_rdata,
    // cpu side requests
    input  wire logic              cpu_req,
    input  wire ebw_req_t          cpu_req_data,
    output logic                   cpu_ready,
    output logic                   rd_valid,
    output logic [DATA_W-1:0]      rd_data,
    // boot rom
    input  wire logic              boot_mode_select,
    output logic [ROM_AW-1:0]      rom_addr,
    input  wire logic [DATA_W-1:0] rom_rdata,
    // external bus
    output logic [ADDR_W-1:0]      ext_addr,
    output logic                   ext_rw,
    output logic                   bus_strobe_n,
    output logic [3:0]             page_select_n,
    output logic [DATA_W-1:0]      ext_data_out,
    input  wire logic [DATA_W-1:0] ext_data_in,
    output logic                   ext_data_oe_n,
    output logic                   bus_oe_n,
    output logic                   keeper_en,
    input  wire logic              ready_n,
    input  wire logic              output_float_pin_n
);

    // ****************************************
    // declarations
    // ****************************************
    ebw_state_s_t      s;                      // registered state
    ebw_state_s_t      next_s;                 // next state
    ebw_req_t          start_req;              // request that opens an access
    logic [3:0]        start_page;             // page for that request
    logic              done;                   // access ends this cycle
    logic              wait_done;              // wait counter reached its field
    logic              launch;                 // open an external access
    logic              take;                   // request accepted this cycle
    logic              rom_hit;                // request falls into the boot rom
    logic              new_bank;               // request targets another bank than the last access
    logic              pin_rst_n;              // reset of the pin enables
    logic              bus_oe_q;               // address and strobe enable, low drives
    logic              data_oe_q;              // data enable, low drives
    logic              keep_q;                 // keeper enable

    // reset image: strobe and selects idle high, control defaults
    localparam ebw_state_s_t S_RST = '{
        st:       EBW_IDLE,
        ctrl:     '{rdy_sel: SEL_RST, wait_cnt: WCNT_RST, bank_cmp: BNK_RST},
        strobe_n: 1'b1,
        page_n:   4'hF,
        default:  '0
    };

    // ****************************************
    // helpers
    // ****************************************
    // a request is taken only while the latch is empty
    assign take      = cpu_req && s.cpu_ready;
    // the count starts at zero, a field of n gives n+1 cycles
    assign wait_done = s.wcnt >= s.ctrl.wait_cnt;
    // during the null cycle the latch already holds the request
    assign start_req = (s.st == EBW_NULL) ? s.req : cpu_req_data;
    assign rom_hit   = boot_mode_select && (cpu_req_data.addr <= ROM_HI);
    // only external accesses move the bank, rom reads do not
    assign new_bank  = s.last_valid
                    && (((cpu_req_data.addr ^ s.last_addr) & bank_mask(s.ctrl.bank_cmp)) != '0);

    // page decode for the request being launched
    ebw_page_decode #(
        .PAGES     (4)
    ) u_page (
        .page_bits (start_req.addr[PAGE_LO +: 2]),
        .active    (1'b1),
        .page      (start_page)
    );

    // one control register sets the ready source for every page
    ebw_ready_sel u_ready (
        .sel       (s.ctrl.rdy_sel),
        .ready_n   (ready_n),
        .wait_done (wait_done),
        .done      (done)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_s          = s;
        next_s.rd_valid = 1'b0;
        launch          = 1'b0;
        // register writes take effect at the next edge
        if (reg_wr && reg_addr == CTRL_OFS) begin
            next_s.ctrl.rdy_sel  = reg_wdata[SEL_LSB +: 2];
            next_s.ctrl.wait_cnt = reg_wdata[WCNT_LSB +: 3];
            next_s.ctrl.bank_cmp = reg_wdata[BNK_LSB +: 5];
        end
        // register reads answer one cycle later, unmapped reads give zero
        if (reg_rd) begin
            case (reg_addr)
                CTRL_OFS: next_s.reg_rdata = DATA_W'({s.ctrl.bank_cmp, s.ctrl.wait_cnt,
                                                      s.ctrl.rdy_sel, 3'h0});
                STAT_OFS: next_s.reg_rdata = DATA_W'({s.wcnt, s.st, s.req.we,
                                                      !s.cpu_ready});
                default:  next_s.reg_rdata = '0;
            endcase
        end
        // bus sequencer
        case (s.st)
            EBW_IDLE: begin
                if (take) begin
                    // the latch holds the request, the cpu waits until the bus is quiet
                    next_s.req = cpu_req_data;
                    if (rom_hit) begin
                        // rom writes are dropped, the bus stays quiet
                        if (!cpu_req_data.we) begin
                            next_s.st       = EBW_ROM;
                            next_s.rom_addr = cpu_req_data.addr[ROM_AW-1:0];
                        end
                    end else if (!cpu_req_data.we && s.ctrl.bank_cmp != '0 && new_bank) begin
                        // reads to a new bank give slow devices a cycle to let go
                        next_s.st = EBW_NULL;
                    end else begin
                        launch = 1'b1;
                    end
                end
            end
            EBW_NULL: begin
                // strobe opens one cycle late, same latched request
                launch = 1'b1;
            end
            EBW_ACC: begin
                // ready is sampled at each rising edge of the phase-one clock
                if (done) begin
                    // strobe and selects rise together
                    next_s.strobe_n = 1'b1;
                    next_s.page_n   = 4'hF;
                    next_s.drive    = 1'b0;
                    next_s.st       = EBW_IDLE;
                    if (s.ext_rw) begin
                        // read data taken in the last strobe-low cycle
                        next_s.rd_data  = ext_data_in;
                        next_s.rd_valid = 1'b1;
                    end
                end else if (s.wcnt != 3'h7) begin
                    // saturate, a long pin stall must not wrap it
                    next_s.wcnt = s.wcnt + 3'h1;
                end
            end
            EBW_ROM: begin
                // rom data stand one cycle after rom_addr
                next_s.rd_data  = rom_rdata;
                next_s.rd_valid = 1'b1;
                next_s.st       = EBW_IDLE;
            end
            default: begin
                next_s.st = EBW_IDLE;
            end
        endcase
        // open the access: strobe and one page select fall together
        if (launch) begin
            next_s.st         = EBW_ACC;
            // address and data held to the end of the access
            next_s.ext_addr   = start_req.addr;
            next_s.ext_rw     = !start_req.we;
            next_s.strobe_n   = 1'b0;
            next_s.page_n     = ~start_page;
            next_s.drive      = start_req.we;
            next_s.wcnt       = 3'h0;
            next_s.last_addr  = start_req.addr;
            next_s.last_valid = 1'b1;
            if (start_req.we) begin
                next_s.dout = start_req.data;
            end
        end
        // undriven data pins keep their last level through the keeper
        if (!next_s.drive) begin
            next_s.dout = ext_data_in;
        end
        // the latch is free again once the bus is quiet
        next_s.cpu_ready = (next_s.st == EBW_IDLE);
    end

    // ****************************************
    // state register
    // ****************************************
    // whole sequencer state in one register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= S_RST;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************
    // pin enables
    // ****************************************
    // the float pin joins the reset so the pins let go without a clock;
    // the cost is a gated reset net, kept to these three flops only
    assign pin_rst_n = rst_n && output_float_pin_n;

    always_ff @(posedge clk or negedge pin_rst_n) begin
        if (!pin_rst_n) begin
            bus_oe_q  <= 1'b1;
            data_oe_q <= 1'b1;
            keep_q    <= 1'b0;
        end else begin
            bus_oe_q  <= 1'b0;
            // data enable lines up with the drive flag of the state
            data_oe_q <= !next_s.drive;
            keep_q    <= 1'b1;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // each output is a state flop or a pin enable flop
    assign reg_rdata     = s.reg_rdata;
    assign cpu_ready     = s.cpu_ready;
    assign rd_valid      = s.rd_valid;
    assign rd_data       = s.rd_data;
    assign rom_addr      = s.rom_addr;
    assign ext_addr      = s.ext_addr;
    assign ext_rw        = s.ext_rw;
    assign bus_strobe_n  = s.strobe_n;
    assign page_select_n = s.page_n;
    assign ext_data_out  = s.dout;
    assign ext_data_oe_n = data_oe_q;
    assign bus_oe_n      = bus_oe_q;
    assign keeper_en     = keep_q;

    // ****************************************
    // checks
    // ****************************************
    // four bits cover the longest counted strobe of eight
    logic [3:0] strobe_len;                    // cycles of the current strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strobe_len <= 4'h0;
        end else begin
            strobe_len <= bus_strobe_n ? 4'h0 : strobe_len + 4'h1;
        end
    end

    // all checks sample at the phase-one rising edge
    page_range_a: assert property (@(posedge clk) disable iff (!rst_n)
        !bus_strobe_n |-> $onehot(~page_select_n) && !page_select_n[ext_addr[23:22]])
        else $error("page select does not match the address");

    page_timing_a: assert property (@(posedge clk) disable iff (!rst_n)
        bus_strobe_n == (&page_select_n))
        else $error("page select and strobe differ");

    count_length_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(bus_strobe_n) && s.ctrl.rdy_sel == RDY_CNT
        |-> strobe_len == {1'b0, s.ctrl.wait_cnt} + 4'h1)
        else $error("counter mode strobe length wrong");

    pin_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
        !bus_strobe_n && s.ctrl.rdy_sel == RDY_PIN && ready_n |=> !bus_strobe_n)
        else $error("pin mode ended without ready");

    and_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        !bus_strobe_n && s.ctrl.rdy_sel == RDY_AND && !ready_n |=> bus_strobe_n)
        else $error("and mode did not end on low ready");

    null_cycle_a: assert property (@(posedge clk) disable iff (!rst_n)
        s.st == EBW_NULL |-> bus_strobe_n && !s.req.we ##1 !bus_strobe_n && ext_rw)
        else $error("null cycle not followed by a read");

    or_extend_a: assert property (@(posedge clk) disable iff (!rst_n)
        !bus_strobe_n && s.ctrl.rdy_sel == RDY_OR && (ready_n || !wait_done)
        |=> !bus_strobe_n)
        else $error("or mode access ended early");

    posted_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        take && cpu_req_data.we && !rom_hit
        |=> !bus_strobe_n && !ext_rw && ext_data_out == $past(cpu_req_data.data))
        else $error("posted write not placed on the bus");

    rom_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
        take && rom_hit && !cpu_req_data.we |=> bus_strobe_n ##1 rd_valid && bus_strobe_n)
        else $error("boot rom read touched the bus");

    float_pins_a: assert property (@(posedge clk) disable iff (!rst_n)
        !output_float_pin_n |-> bus_oe_n && ext_data_oe_n && !keeper_en)
        else $error("outputs not floated");

    addr_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !bus_strobe_n && !ext_rw && !$past(bus_strobe_n)
        |-> $stable(ext_addr) && $stable(ext_data_out))
        else $error("posted write moved under the strobe");

    keeper_on_a: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) && output_float_pin_n && $past(output_float_pin_n)
        |-> keeper_en && !bus_oe_n)
        else $error("keeper or bus drive off while not floated");

    rom_no_bus_a: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(bus_strobe_n) && $past(boot_mode_select)
        |-> ext_addr > ROM_HI)
        else $error("boot rom address reached the bus");

    or_minimum_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(bus_strobe_n) && s.ctrl.rdy_sel == RDY_OR
        |-> strobe_len >= {1'b0, s.ctrl.wait_cnt} + 4'h1)
        else $error("or mode strobe shorter than count");

    and_maximum_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(bus_strobe_n) && s.ctrl.rdy_sel == RDY_AND
        |-> strobe_len <= {1'b0, s.ctrl.wait_cnt} + 4'h1)
        else $error("and mode strobe longer than count");

endmodule // ebw_bus_ctrl

// *** core/ebw_page_decode.sv ***
// module: page decode of the top two address bits into four selects
`timescale 1ns/100ps
module ebw_page_decode
    import ebw_pkg::*;
#(
    parameter int PAGES = 4                     // number of page selects
) (
    // decode input
    input  wire logic [1:0]       page_bits,
    input  wire logic             active,
    // one-hot select
    output logic [PAGES-1:0]      page
);

    // ****************************************
    // elaboration check
    // ****************************************
    if (PAGES != 4) begin : g_bad_pages
        $error("ebw_page_decode: two address bits serve exactly four pages");
    end

    // ****************************************
    // one compare per page
    // ****************************************
    for (genvar g = 0; g < PAGES; g++) begin : g_page
        // only one page can match, so the result is one-hot when active
        assign page[g] = active && (page_bits == 2'(g));
    end

endmodule // ebw_page_decode

// *** core/ebw_ready_sel.sv ***
// module: ready source select, merges the ready pin with the wait counter
`timescale 1ns/100ps
module ebw_ready_sel
    import ebw_pkg::*;
(
    // select and sources
    input  wire logic [1:0] sel,
    input  wire logic       ready_n,
    input  wire logic       wait_done,
    // access may end in this cycle
    output logic            done
);

    // ****************************************
    // ready mux
    // ****************************************
    // ready pin is active low: low lets the access finish
    always_comb begin
        case (sel)
            RDY_PIN: done = !ready_n;                  // pin only
            RDY_CNT: done = wait_done;                 // counter only
            RDY_AND: done = !ready_n || wait_done;     // low pin ends at once
            RDY_OR:  done = !ready_n && wait_done;     // never shorter than count
            default: done = wait_done;
        endcase
    end

endmodule // ebw_ready_sel

// *** tb/ebw_ext_mem.sv ***
// partner model: external memory with programmable ready latency and pin resolution
`timescale 1ns/100ps
module ebw_ext_mem
    import ebw_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // bus from the device
    input  wire logic [ADDR_W-1:0] ext_addr,
    input  wire logic              ext_rw,
    input  wire logic              bus_strobe_n,
    input  wire logic [DATA_W-1:0] ext_data_out,
    input  wire logic              ext_data_oe_n,
    input  wire logic              keeper_en,
    // stall length in strobe-low cycles
    input  wire logic [3:0]        lat,
    // answers to the device
    output logic                   ready_n,
    output logic [DATA_W-1:0]      ext_data_in
);
    logic [DATA_W-1:0] mem [0:15];              // tiny store, page bits kept in the index
    logic [3:0]        cnt;                     // strobe-low cycles seen so far
    logic [3:0]        idx;                     // store index
    assign idx = {ext_addr[23:22], ext_addr[1:0]};
    // ready held high to stall, driven low to let the access end
    assign ready_n = !(!bus_strobe_n && cnt >= lat);
    // pin level: device drive, memory drive in a read, keeper, else a value that moves
    assign ext_data_in = !ext_data_oe_n ? ext_data_out
                       : (!bus_strobe_n && ext_rw) ? mem[idx]
                       : keeper_en ? ext_data_out : ~ext_data_out;
    // count stall cycles and take write data while strobed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 4'h0;
        end else if (bus_strobe_n) begin
            cnt <= 4'h0;
        end else begin
            cnt <= cnt + 4'h1;
            if (!ext_rw) begin
                mem[idx] <= ext_data_out;
            end
        end
    end
endmodule // ebw_ext_mem

// *** tb/external_bus_wait_state_control_tb.sv ***
// testbench: page selects, ready modes, bank compare, boot rom and float
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, b); end end
module external_bus_wait_state_control_tb import ebw_pkg::*;;
    logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, cpu_req = 1'b0;
    logic boot_mode_select = 1'b0, output_float_pin_n = 1'b1;
    logic [REG_AW-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, rd_data, rom_rdata, ext_data_out, ext_data_in;
    ebw_req_t          cpu_req_data = '0;
    logic [ROM_AW-1:0] rom_addr;
    logic [ADDR_W-1:0] ext_addr;
    logic [3:0]        page_select_n, lat = 4'h0;
    logic cpu_ready, rd_valid, ext_rw, bus_strobe_n, ext_data_oe_n, bus_oe_n, keeper_en, ready_n;
    logic [31:0]       q;                       // last read result
    int n_mismatch = 0, check_count = 0, nl, dl, s, t;
    always #5 clk = ~clk;
    // rom content is its own address under a fixed tag, easy to predict
    assign rom_rdata = {20'hABCDE, rom_addr};
    ebw_bus_ctrl u_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .cpu_req, .cpu_req_data, .cpu_ready, .rd_valid, .rd_data, .boot_mode_select, .rom_addr,
        .rom_rdata, .ext_addr, .ext_rw, .bus_strobe_n, .page_select_n, .ext_data_out,
        .ext_data_in, .ext_data_oe_n, .bus_oe_n, .keeper_en, .ready_n, .output_float_pin_n);
    ebw_ext_mem u_mem (.clk, .rst_n, .ext_addr, .ext_rw, .bus_strobe_n, .ext_data_out,
        .ext_data_oe_n, .keeper_en, .lat, .ready_n, .ext_data_in);
    // ****************************************
    // tasks
    // ****************************************
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // read data stand from the cycle after the strobe until the next read
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    // one cpu access; counts strobe-low cycles and the delay to the strobe
    task automatic acc(input logic we, input logic [23:0] a, input logic [31:0] d);
        int k;
        nl = 0;
        dl = 0;
        for (k = 0; k < 50 && cpu_ready !== 1'b1; k++) @(negedge clk);
        if (k >= 50) begin
            n_mismatch++;
            tally_and_finish();
        end
        @(posedge clk);
        cpu_req <= 1'b1;
        cpu_req_data <= '{we, a, d};
        @(posedge clk);
        cpu_req <= 1'b0;
        // the strobe is low right after the taking edge, or one cycle later after a null cycle
        for (k = 1; k < 200; k++) begin
            #1;
            if (rd_valid === 1'b1) q = rd_data;
            if (bus_strobe_n === 1'b0) begin
                if (nl == 0) dl = k;
                nl++;
                `CHK(page_select_n, ~(4'h1 << a[23:22]))
                `CHK(ext_addr, a)
                `CHK({ext_rw, cpu_ready}, {!we, 1'b0})
                if (we) `CHK(ext_data_out, d)
            end else if (nl > 0 || rd_valid === 1'b1) begin
                `CHK(cpu_ready, 1'b1)
                break;
            end else `CHK(page_select_n, 4'hF)
            @(posedge clk);
        end
        if (k >= 200) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask
    // expected strobe length per ready source, latency and wait count
    function automatic int exp_len(int m, int l, int w);
        case (m)
            0: return l + 1;
            1: return w + 1;
            2: return (l == 0) ? 1 : ((l < w) ? l + 1 : w + 1);
            default: return (l > w) ? l + 1 : w + 1;
        endcase
    endfunction
    // hang guard, counted as a mismatch
    initial begin
        #1000000;
        n_mismatch++;
        tally_and_finish();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        reg_read(CTRL_OFS, q);
        `CHK(q, 32'h000000F8)
        reg_read(8'h08, q);
        `CHK(q, 32'h00000000)
        $display("test reset done");
        for (s = 0; s < 4; s++) begin
            acc(1'b1, {s[1:0], 22'h000003}, 32'hA5A50000 + s);
            `CHK(nl, 8)
            acc(1'b0, {s[1:0], 22'h000003}, '0);
            `CHK(q, 32'hA5A50000 + s)
        end
        $display("test pages done");
        for (s = 0; s < 4; s++) begin
            for (t = 0; t < 2; t++) begin
                reg_write(CTRL_OFS, {19'h0, 5'h00, 3'h2, s[1:0], 3'h0});
                lat <= (t == 1) ? 4'h4 : 4'h0;
                acc(1'b0, 24'h000003, '0);
                `CHK(nl, exp_len(s, t * 4, 2))
            end
        end
        $display("test ready modes done");
        reg_write(CTRL_OFS, {19'h0, 5'h02, 3'h0, RDY_CNT, 3'h0});
        lat <= 4'h0;
        acc(1'b0, 24'h000003, '0);
        acc(1'b0, 24'h400003, '0);
        `CHK(dl, 2)
        acc(1'b0, 24'h400002, '0);
        `CHK(dl, 1)
        acc(1'b1, 24'h800001, 32'h00000005);
        `CHK(dl, 1)
        `CHK({ext_data_oe_n, keeper_en, ext_data_out}, {2'b11, 32'h00000005})
        $display("test bank compare done");
        boot_mode_select <= 1'b1;
        acc(1'b0, 24'h000010, '0);
        `CHK(nl, 0)
        `CHK(q, 32'hABCDE010)
        acc(1'b0, 24'h001000, '0);
        `CHK(nl, 1)
        boot_mode_select <= 1'b0;
        $display("test boot done");
        @(posedge clk);
        output_float_pin_n <= 1'b0;
        #1;
        `CHK({bus_oe_n, ext_data_oe_n, keeper_en}, 3'b110)
        @(posedge clk);
        output_float_pin_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        `CHK({bus_oe_n, keeper_en}, 2'b01)
        $display("test float done");
        tally_and_finish();
    end
endmodule // external_bus_wait_state_control_tb
